// ### logic/dcm_pkg.sv
`default_nettype none
package dcm_pkg;
	// Register byte offsets; printed offsets are not multiples of four,
	// so each is kept as an index and the byte address is four times it
	localparam logic [5:0] DCM_IDX_ADDR_HIGH = 6'h29;
	localparam logic [5:0] DCM_IDX_ADDR_MID = 6'h2A;
	localparam logic [5:0] DCM_IDX_ADDR_LOW = 6'h2B;
	localparam logic [5:0] DCM_IDX_DATA_HIGH = 6'h2C;
	localparam logic [5:0] DCM_IDX_DATA_LOW = 6'h2D;
	localparam logic [5:0] DCM_IDX_MASK_HIGH = 6'h2E;
	localparam logic [5:0] DCM_IDX_MASK_LOW = 6'h2F;
	// Control registers gathered into words of our own
	localparam logic [5:0] DCM_IDX_CONTROL = 6'h30;
	localparam logic [5:0] DCM_IDX_COMP_CTRL_A = 6'h31;
	localparam logic [5:0] DCM_IDX_COMP_CTRL_B = 6'h32;
	localparam logic [5:0] DCM_IDX_COMP_CTRL_C = 6'h33;
	localparam logic [5:0] DCM_IDX_STATUS = 6'h34;
	// Field positions
	localparam int DCM_CTL_ARM_BIT = 7;
	localparam int DCM_CTL_VIEW_LSB = 0;
	localparam int DCM_CC_TAG_BIT = 5;
	localparam int DCM_CC_NDB_BIT = 1;
	localparam int DCM_CC_ENABLE_BIT = 0;
	// View-select codes
	localparam logic [1:0] DCM_VIEW_A = 2'h0;
	localparam logic [1:0] DCM_VIEW_B = 2'h1;
	localparam logic [1:0] DCM_VIEW_C = 2'h2;
	// Reset values and widths
	localparam logic [7:0] DCM_RESET_BYTE = 8'h00;
	localparam logic [17:0] DCM_RESET_ADDR = 18'h00000;
	localparam int DCM_ADDR_W = 18;
	localparam int DCM_DATA_W = 16;
	localparam int DCM_NUM_COMP = 3;
endpackage : dcm_pkg
`default_nettype wire

// ### logic/dcm_addr_store.sv
`default_nettype none
// Three 18-bit comparator address words, written one byte lane at a time
module dcm_addr_store (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Write side
	input wire logic [1:0] wr_sel,
	input wire logic [2:0] wr_lane,
	input wire logic [7:0] wr_byte,
	// Stored values, all three visible to the comparators at once
	output logic [dcm_pkg::DCM_ADDR_W-1:0] addr_a,
	output logic [dcm_pkg::DCM_ADDR_W-1:0] addr_b,
	output logic [dcm_pkg::DCM_ADDR_W-1:0] addr_c
);
	import dcm_pkg::*;

	logic [DCM_ADDR_W-1:0] store [DCM_NUM_COMP];

	// Byte-lane writes; lane 2 keeps only bits 17:16
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < DCM_NUM_COMP; i++) begin
				store[i] <= DCM_RESET_ADDR;
			end
		end else if (wr_sel != 2'h3) begin
			if (wr_lane[2]) begin
				store[wr_sel][17:16] <= wr_byte[1:0];
			end
			if (wr_lane[1]) begin
				store[wr_sel][15:8] <= wr_byte;
			end
			if (wr_lane[0]) begin
				store[wr_sel][7:0] <= wr_byte;
			end
		end
	end

	assign addr_a = store[0];
	assign addr_b = store[1];
	assign addr_c = store[2];
endmodule : dcm_addr_store
`default_nettype wire

// ### logic/dcm_match_regs.sv
// The APB interface to the registers was left to the implementer.
`default_nettype none
module dcm_match_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU bus monitored, same clock
	input wire logic bus_valid,
	input wire logic [dcm_pkg::DCM_ADDR_W-1:0] bus_addr,
	input wire logic [dcm_pkg::DCM_DATA_W-1:0] bus_data,
	// Arm clear from the sequencer, same clock
	input wire logic disarm,
	// Per-comparator match and state
	output logic [dcm_pkg::DCM_NUM_COMP-1:0] comp_match,
	output logic armed,
	output logic [1:0] comparator_view_select
);
	import dcm_pkg::*;

	typedef enum logic [1:0] {
		DCM_IDLE,
		DCM_ACCESS
	} dcm_state_t;

	dcm_state_t state;
	logic [7:0] comparator_data_high;
	logic [7:0] comparator_data_low;
	logic [7:0] comparator_data_high_mask;
	logic [7:0] comparator_data_low_mask;
	logic [7:0] comparator_a_control;
	logic [7:0] comparator_b_control;
	logic [7:0] comparator_c_control;
	logic [DCM_ADDR_W-1:0] addr_a;
	logic [DCM_ADDR_W-1:0] addr_b;
	logic [DCM_ADDR_W-1:0] addr_c;
	logic [1:0] wr_sel;
	logic [2:0] wr_lane;
	logic [5:0] idx;
	logic addr_ok;
	logic wr_en;
	logic wr_unlocked;
	logic [31:0] next_prdata;
	logic next_err;
	logic [DCM_NUM_COMP-1:0] next_match;
	logic [15:0] data_ref;
	logic [15:0] data_mask;

	// Word index from the byte address; low two bits must be zero
	function automatic logic [5:0] word_index(input logic [11:0] a);
		word_index = a[7:2];
	endfunction : word_index

	// Address equality, bit for bit
	function automatic logic addr_hit(
		input logic [DCM_ADDR_W-1:0] stored,
		input logic [DCM_ADDR_W-1:0] bus
	);
		addr_hit = (stored == bus);
	endfunction : addr_hit

	// Access decode
	assign idx = word_index(paddr);
	assign addr_ok = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
	assign wr_en = psel && penable && pwrite && pready && !pslverr;
	assign wr_unlocked = wr_en && !armed;

	// Lane strobes into the address store
	always_comb begin
		wr_sel = 2'h3;
		wr_lane = 3'h0;
		if (wr_unlocked && comparator_view_select != 2'h3) begin
			wr_sel = comparator_view_select;
			wr_lane[2] = (idx == DCM_IDX_ADDR_HIGH);
			wr_lane[1] = (idx == DCM_IDX_ADDR_MID);
			wr_lane[0] = (idx == DCM_IDX_ADDR_LOW);
		end
	end

	dcm_addr_store u_store (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.wr_sel(wr_sel),
		.wr_lane(wr_lane),
		.wr_byte(pwdata[7:0]),
		.addr_a(addr_a),
		.addr_b(addr_b),
		.addr_c(addr_c)
	);

	// Read mux and error decode for the upcoming access phase
	always_comb begin
		logic [DCM_ADDR_W-1:0] sel_addr;
		logic view_a;
		sel_addr = DCM_RESET_ADDR;
		view_a = (comparator_view_select == DCM_VIEW_A);
		case (comparator_view_select)
			DCM_VIEW_A: sel_addr = addr_a;
			DCM_VIEW_B: sel_addr = addr_b;
			DCM_VIEW_C: sel_addr = addr_c;
			default: sel_addr = DCM_RESET_ADDR;
		endcase
		next_prdata = 32'h00000000;
		next_err = !addr_ok;
		if (addr_ok) begin
			case (idx)
				DCM_IDX_ADDR_HIGH:
					next_prdata[1:0] = sel_addr[17:16];
				DCM_IDX_ADDR_MID:
					next_prdata[7:0] = sel_addr[15:8];
				DCM_IDX_ADDR_LOW:
					next_prdata[7:0] = sel_addr[7:0];
				DCM_IDX_DATA_HIGH:
					next_prdata[7:0] = view_a ? comparator_data_high : 8'h00;
				DCM_IDX_DATA_LOW:
					next_prdata[7:0] = view_a ? comparator_data_low : 8'h00;
				DCM_IDX_MASK_HIGH:
					next_prdata[7:0] = view_a ? comparator_data_high_mask : 8'h00;
				DCM_IDX_MASK_LOW:
					next_prdata[7:0] = view_a ? comparator_data_low_mask : 8'h00;
				DCM_IDX_CONTROL: begin
					next_prdata[DCM_CTL_ARM_BIT] = armed;
					next_prdata[1:0] = comparator_view_select;
				end
				DCM_IDX_COMP_CTRL_A: next_prdata[7:0] = comparator_a_control;
				DCM_IDX_COMP_CTRL_B: next_prdata[7:0] = comparator_b_control;
				DCM_IDX_COMP_CTRL_C: next_prdata[7:0] = comparator_c_control;
				DCM_IDX_STATUS: next_prdata[2:0] = comp_match;
				default: next_err = 1'b1;
			endcase
		end
	end

	// APB handshake: one wait state so read data comes from a flip-flop
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= DCM_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			case (state)
				DCM_IDLE: begin
					pready <= 1'b0;
					pslverr <= 1'b0;
					if (psel && penable) begin
						state <= DCM_ACCESS;
						pready <= 1'b1;
						pslverr <= next_err;
						prdata <= pwrite ? 32'h00000000 : next_prdata;
					end
				end
				DCM_ACCESS: begin
					state <= DCM_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					state <= DCM_IDLE;
					pready <= 1'b0;
				end
			endcase
		end
	end

	// Arm and view select; a disarm from the sequencer wins over a set
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			armed <= 1'b0;
			comparator_view_select <= DCM_VIEW_A;
		end else if (disarm) begin
			armed <= 1'b0;
		end else if (wr_en && idx == DCM_IDX_CONTROL) begin
			armed <= pwdata[DCM_CTL_ARM_BIT];
			if (!armed) begin
				comparator_view_select <= pwdata[DCM_CTL_VIEW_LSB +: 2];
			end
		end
	end

	// Comparator A data and mask; locked while armed or viewing anything but A
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			comparator_data_high <= DCM_RESET_BYTE;
			comparator_data_low <= DCM_RESET_BYTE;
			comparator_data_high_mask <= DCM_RESET_BYTE;
			comparator_data_low_mask <= DCM_RESET_BYTE;
		end else if (wr_unlocked && comparator_view_select == DCM_VIEW_A) begin
			case (idx)
				DCM_IDX_DATA_HIGH: comparator_data_high <= pwdata[7:0];
				DCM_IDX_DATA_LOW: comparator_data_low <= pwdata[7:0];
				DCM_IDX_MASK_HIGH:
					comparator_data_high_mask <= pwdata[7:0];
				DCM_IDX_MASK_LOW:
					comparator_data_low_mask <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Comparator control words, also locked while armed
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			comparator_a_control <= DCM_RESET_BYTE;
			comparator_b_control <= DCM_RESET_BYTE;
			comparator_c_control <= DCM_RESET_BYTE;
		end else if (wr_unlocked) begin
			case (idx)
				DCM_IDX_COMP_CTRL_A: comparator_a_control <= pwdata[7:0];
				// Only A carries the not-data-bus bit
				DCM_IDX_COMP_CTRL_B:
					comparator_b_control <= pwdata[7:0] & 8'hFD;
				DCM_IDX_COMP_CTRL_C:
					comparator_c_control <= pwdata[7:0] & 8'hFD;
				default: ;
			endcase
		end
	end

	// Match decision
	assign data_ref = {comparator_data_high, comparator_data_low};
	assign data_mask = {comparator_data_high_mask, comparator_data_low_mask};
	always_comb begin
		logic data_eq;
		logic data_ok;
		data_eq = 1'b0;
		data_ok = 1'b0;
		data_eq = ((bus_data ^ data_ref) & data_mask) == 16'h0000;
		if (comparator_a_control[DCM_CC_TAG_BIT]) begin
			data_ok = 1'b1;
		end else if (comparator_a_control[DCM_CC_NDB_BIT]) begin
			data_ok = !data_eq;
		end else begin
			data_ok = data_eq;
		end
		next_match[0] = comparator_a_control[DCM_CC_ENABLE_BIT]
			&& addr_hit(addr_a, bus_addr) && data_ok;
		next_match[1] = comparator_b_control[DCM_CC_ENABLE_BIT]
			&& addr_hit(addr_b, bus_addr);
		next_match[2] = comparator_c_control[DCM_CC_ENABLE_BIT]
			&& addr_hit(addr_c, bus_addr);
	end

	// Registered match; matches only count while armed and a cycle is valid
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			comp_match <= 3'h0;
		end else begin
			comp_match <= (bus_valid && armed) ? next_match : 3'h0;
		end
	end
endmodule : dcm_match_regs
`default_nettype wire

// ### dv/dcm_match_regs_props.sv
`default_nettype none
// Port-level checks on the comparator register block
module dcm_match_regs_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Monitored bus and state
	input wire logic bus_valid,
	input wire logic disarm,
	input wire logic [dcm_pkg::DCM_NUM_COMP-1:0] comp_match,
	input wire logic armed,
	input wire logic [1:0] comparator_view_select
);
	timeunit 1ns;
	timeprecision 1ps;
	import dcm_pkg::*;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// Access phase still open, and a finished read of one place
	sequence s_wait; psel && penable && !pready; endsequence
	sequence s_rd(a); pready && !pwrite && paddr == a; endsequence
	// At most one wait state; a late slave would hang software
	property p_answer; s_wait |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("late answer");
	property p_in_xfer; pready |-> psel && penable; endproperty
	a_in_xfer: assert property (p_in_xfer) else $error("stray ready");
	property p_align; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
	a_align: assert property (p_align) else $error("no error");
	property p_high; s_rd(12'hA4) |-> prdata[31:2] == 30'h0; endproperty
	a_high: assert property (p_high) else $error("high bits set");
	property p_hidden;
		pready && !pwrite && paddr[11:4] == 8'h0B &&
		comparator_view_select != 2'h0 |-> prdata == 32'h0;
	endproperty
	a_hidden: assert property (p_hidden) else $error("data visible");
	property p_none;
		pready && !pwrite && paddr[11:4] == 8'h0A &&
		comparator_view_select == 2'h3 |-> prdata == 32'h0;
	endproperty
	a_none: assert property (p_none) else $error("view 3 shows");
	property p_match;
		comp_match != 3'h0 |-> $past(armed) && $past(bus_valid);
	endproperty
	a_match: assert property (p_match) else $error("bad match");
	property p_disarm; disarm |=> !armed; endproperty
	a_disarm: assert property (p_disarm) else $error("still armed");
endmodule : dcm_match_regs_props
bind dcm_match_regs dcm_match_regs_props u_props (.*);
`default_nettype wire

// ### dv/dcm_cpu_model.sv
`default_nettype none
// CPU side: one qualified bus cycle on request, scrambled buses when idle
module dcm_cpu_model (
	// Clock
	input wire logic ref_clk,
	// Monitored CPU buses
	output logic bus_valid,
	output logic [dcm_pkg::DCM_ADDR_W-1:0] bus_addr,
	output logic [dcm_pkg::DCM_DATA_W-1:0] bus_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import dcm_pkg::*;
	logic go = 1'b0;
	logic [DCM_ADDR_W-1:0] next_addr;
	logic [DCM_DATA_W-1:0] next_data;
	// Idle values flip each cycle so stale data never passes for a cycle
	initial begin
		bus_valid = 1'b0;
		bus_addr = 18'h00000;
		bus_data = 16'h0000;
	end
	always @(posedge ref_clk) begin
		bus_valid <= go;
		bus_addr <= go ? next_addr : ~bus_addr;
		bus_data <= go ? next_data : ~bus_data;
	end
	// Gap lets a cycle come late; returns at the sampling edge, before the match registers update
	task automatic cycle(input logic [17:0] a, input logic [15:0] d,
		input int gap);
		repeat (gap) @(posedge ref_clk);
		#1;
		next_addr = a;
		next_data = d;
		go = 1'b1;
		@(posedge ref_clk);
		#1;
		go = 1'b0;
		@(posedge ref_clk);
	endtask : cycle
endmodule : dcm_cpu_model
`default_nettype wire

// ### dv/dcm_match_regs_tb_top.sv
`default_nettype none
module dcm_match_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dcm_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, disarm = 1'b0, pready, pslverr, armed, err;
	logic bus_valid;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [17:0] bus_addr;
	logic [15:0] bus_data;
	logic [2:0] comp_match;
	logic [1:0] comparator_view_select;
	int fails = 0, n_compared = 0;
	logic [17:0] ca [3] = '{18'h21234, 18'h1ABCD, 18'h00F0F};
	logic [7:0] dv [4] = '{8'h5A, 8'h3C, 8'hFF, 8'h00};
	// Block, CPU model; the checker comes in by bind
	dcm_match_regs u_dut (.*);
	dcm_cpu_model u_cpu (.*);
	initial forever #10 ref_clk = ~ref_clk;
	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Idle edge first, so back-to-back calls never drive twice at one edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask : rd
	// Reset values, banking by view, hidden data, bad address
	task automatic t_regs;
		for (int i = 0; i < 7; i++) rd(12'hA4 + 12'(4 * i), 32'h0);
		for (int v = 0; v < 3; v++) begin
			apb(1'b1, 12'hC0, 8'(v));
			apb(1'b1, 12'hA4, {6'h3F, ca[v][17:16]});
			apb(1'b1, 12'hA8, ca[v][15:8]);
			apb(1'b1, 12'hAC, ca[v][7:0]);
		end
		for (int v = 0; v < 3; v++) begin
			apb(1'b1, 12'hC0, 8'(v));
			rd(12'hA4, {30'h0, ca[v][17:16]});
			rd(12'hA8, {24'h0, ca[v][15:8]});
			rd(12'hAC, {24'h0, ca[v][7:0]});
		end
		apb(1'b1, 12'hC0, 8'h03);
		apb(1'b1, 12'hA8, 8'hFF);
		rd(12'hA8, 32'h0);
		apb(1'b1, 12'hC0, 8'h00);
		for (int i = 0; i < 4; i++) apb(1'b1, 12'hB0 + 12'(4 * i), dv[i]);
		for (int i = 0; i < 4; i++) rd(12'hB0 + 12'(4 * i), {24'h0, dv[i]});
		apb(1'b1, 12'hC0, 8'h01);
		rd(12'hB0, 32'h0);
		rd(12'hA5, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask : t_regs
	// Disarm, set control of A, arm, run one CPU cycle, judge the match
	task automatic mc(input logic [7:0] ctl, input logic [17:0] a,
		input logic [15:0] d, input logic [2:0] exp);
		@(posedge ref_clk);
		disarm <= 1'b1;
		@(posedge ref_clk);
		disarm <= 1'b0;
		apb(1'b1, 12'hC4, ctl);
		apb(1'b1, 12'hC0, 8'h80);
		u_cpu.cycle(a, d, int'(exp));
		#1;
		chk({29'h0, comp_match}, {29'h0, exp});
	endtask : mc
	task automatic t_match;
		apb(1'b1, 12'hC8, 8'h01);
		apb(1'b1, 12'hCC, 8'h01);
		mc(8'h01, ca[0], 16'h5A77, 3'h1);
		mc(8'h01, ca[0], 16'h5B3C, 3'h0);
		mc(8'h01, ca[0] ^ 18'h20000, 16'h5A3C, 3'h0);
		mc(8'h03, ca[0], 16'h5B3C, 3'h1);
		mc(8'h03, ca[0], 16'h5A00, 3'h0);
		mc(8'h21, ca[0], 16'h0000, 3'h1);
		mc(8'h00, ca[0], 16'h5A3C, 3'h0);
		mc(8'h01, ca[1], 16'h0000, 3'h2);
		mc(8'h01, ca[2], 16'hFFFF, 3'h4);
	endtask : t_match
	// Still armed: writes ignored, reads allowed
	task automatic t_lock;
		apb(1'b1, 12'hAC, 8'h99);
		rd(12'hAC, {24'h0, ca[0][7:0]});
		apb(1'b1, 12'hB0, 8'h11);
		rd(12'hB0, 32'h5A);
	endtask : t_lock
	initial begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		t_regs;
		t_match;
		t_lock;
		conclude;
	end
	// Watchdog well past the few hundred cycles the run needs
	initial begin
		#50000;
		fails++;
		conclude;
	end
endmodule : dcm_match_regs_tb_top
`default_nettype wire
